// *** verilog/ptsc_top.sv ***
/*
 * Position triggered scan capture unit with AHB-Lite registers.
 * Assumes one clock hclk at 100 MHz, synchronous channel inputs and
 * a downstream consumer that acknowledges each playback event.
 */
`timescale 1ns/100ps
module ptsc_top #(
  parameter int CH = 4,
  parameter int W = 32,
  parameter int AW = 9
) (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // Measuring channels
  input wire logic [CH*W-1:0] ref_axis_input,
  // Playback stream
  output logic playback_event,
  output logic [CH*W-1:0] playback_data,
  input wire logic playback_ack,
  // Status
  output logic display_suppress,
  output logic irq
);

  // ****************************************
  // Declarations
  // ****************************************
  ptsc_pkg::ptsc_state_e state;
  logic [31:0] ref_sel;
  logic signed [W-1:0] trigger_level;
  logic signed [W-1:0] step_size;
  logic [AW:0] sample_count_target;
  logic [31:0] abort_window;
  logic [31:0] timer;
  logic [AW:0] count;
  logic [AW:0] play_idx;
  logic signed [W-1:0] boundary;
  logic rising;
  logic dir_known;
  logic abort_flag;
  logic [ptsc_pkg::IRQ_BITS-1:0] irq_status;
  logic [ptsc_pkg::IRQ_BITS-1:0] irq_enable;
  logic [ptsc_pkg::IRQ_BITS-1:0] irq_set;
  logic arm_cmd;
  logic capture_clear_command;
  logic ap_valid;
  logic ap_write;
  logic [7:0] ap_addr;
  logic wr_strobe;
  logic signed [W-1:0] ref_pos;
  logic reached;
  logic cross_up;
  logic cross_dn;
  logic capture;
  logic play_wait;
  logic rd_valid;

  ptsc_buf_if #(.CH(CH), .W(W), .AW(AW)) buf_bus ();

  // ****************************************
  // Helpers
  // ****************************************
  // Pick one channel out of the packed vector
  function automatic logic signed [W-1:0] chan(input logic [CH*W-1:0] v,
    input logic [31:0] sel);
    chan = v[W-1:0];
    for (int i = 0; i < CH; i++) begin
      if (sel == 32'(i)) begin
        chan = v[i*W +: W];
      end
    end
  endfunction : chan

  assign ref_pos = chan(ref_axis_input, ref_sel);

  ptsc_step_cmp #(.W(W)) u_cmp (
    .pos(ref_pos),
    .boundary(boundary),
    .step(step_size),
    .rising(rising),
    .reached(reached),
    .cross_up(cross_up),
    .cross_dn(cross_dn)
  );

  ptsc_record_buf #(.CH(CH), .W(W), .AW(AW)) u_buf (
    .hclk(hclk),
    .bus(buf_bus.mem)
  );

  // ****************************************
  // AHB-Lite slave
  // ****************************************
  // Capture address phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ap_valid <= 1'b0;
      ap_write <= 1'b0;
      ap_addr <= 8'h00;
    end else if (hready) begin
      ap_valid <= hsel && htrans[1];
      ap_write <= hwrite;
      ap_addr <= haddr[7:0];
    end
  end

  assign wr_strobe = ap_valid && ap_write;
  assign arm_cmd = wr_strobe && (ap_addr == ptsc_pkg::OFS_CTRL) && hwdata[ptsc_pkg::CTRL_ARM];
  assign capture_clear_command = wr_strobe && (ap_addr == ptsc_pkg::OFS_CTRL)
    && hwdata[ptsc_pkg::CTRL_CLEAR];

  // Zero wait, always OKAY
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
  end

  // Parameter registers
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ref_sel <= ptsc_pkg::RST_WORD;
      trigger_level <= '0;
      step_size <= '0;
      sample_count_target <= '0;
      abort_window <= ptsc_pkg::RST_ABORT_WINDOW;
      irq_enable <= '0;
    end else if (wr_strobe) begin
      case (ap_addr)
        ptsc_pkg::OFS_REF_SEL: ref_sel <= hwdata;
        ptsc_pkg::OFS_TRIGGER_LEVEL: trigger_level <= hwdata[W-1:0];
        ptsc_pkg::OFS_STEP: step_size <= hwdata[W-1:0];
        ptsc_pkg::OFS_SAMPLE_TARGET: sample_count_target <= hwdata[AW:0];
        ptsc_pkg::OFS_ABORT_WINDOW: abort_window <= hwdata;
        ptsc_pkg::OFS_IRQ_ENABLE: irq_enable <= hwdata[ptsc_pkg::IRQ_BITS-1:0];
        default: ;
      endcase
    end
  end

  // Read mux, registered in the address phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0000_0000;
    end else if (hready && hsel && htrans[1] && !hwrite) begin
      case (haddr[7:0])
        ptsc_pkg::OFS_REF_SEL: hrdata <= ref_sel;
        ptsc_pkg::OFS_TRIGGER_LEVEL: hrdata <= 32'(trigger_level);
        ptsc_pkg::OFS_STEP: hrdata <= 32'(step_size);
        ptsc_pkg::OFS_SAMPLE_TARGET: hrdata <= 32'(sample_count_target);
        ptsc_pkg::OFS_ABORT_WINDOW: hrdata <= abort_window;
        ptsc_pkg::OFS_STATUS: hrdata <= {27'h0, display_suppress,
          (state == ptsc_pkg::PTSC_PLAY), (state == ptsc_pkg::PTSC_DONE), abort_flag,
          (state != ptsc_pkg::PTSC_IDLE)};
        ptsc_pkg::OFS_IRQ_STATUS: hrdata <= 32'(irq_status);
        ptsc_pkg::OFS_IRQ_ENABLE: hrdata <= 32'(irq_enable);
        ptsc_pkg::OFS_COUNT: hrdata <= 32'(count);
        ptsc_pkg::OFS_PLAY_INDEX: hrdata <= 32'(play_idx);
        default: hrdata <= 32'h0000_0000;
      endcase
    end
  end

  // ****************************************
  // Capture sequencer
  // ****************************************
  assign capture = ((state == ptsc_pkg::PTSC_WAIT_START) && reached)
    || ((state == ptsc_pkg::PTSC_WAIT_STEP) && (dir_known ? reached : (cross_up || cross_dn)));

  // State, direction, boundary
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state <= ptsc_pkg::PTSC_IDLE;
      boundary <= '0;
      rising <= 1'b1;
      dir_known <= 1'b0;
    end else begin
      case (state)
        ptsc_pkg::PTSC_IDLE: begin
          if (arm_cmd) begin
            state <= ptsc_pkg::PTSC_WAIT_START;
            boundary <= trigger_level;
            rising <= ref_pos <= trigger_level;
            dir_known <= 1'b0;
          end
        end
        ptsc_pkg::PTSC_WAIT_START, ptsc_pkg::PTSC_WAIT_STEP: begin
          if (timer == 32'h0) begin
            state <= ptsc_pkg::PTSC_ABORTED;
          end else if (capture) begin
            if (state == ptsc_pkg::PTSC_WAIT_START) begin
              state <= ptsc_pkg::PTSC_WAIT_STEP;
            end else if (!dir_known) begin
              dir_known <= 1'b1;
              rising <= cross_up;
              // Crossed boundary is spent; aim one step beyond it
              boundary <= cross_up ? boundary + step_size + step_size
                : boundary - step_size - step_size;
            end
            if (dir_known || state == ptsc_pkg::PTSC_WAIT_START) begin
              // Next boundary only in the locked direction
              boundary <= (rising && dir_known) || (state == ptsc_pkg::PTSC_WAIT_START)
                ? boundary + (dir_known ? step_size : '0)
                : boundary - step_size;
            end
            if (count + 1'b1 >= sample_count_target) begin
              state <= ptsc_pkg::PTSC_PLAY;
            end
          end
        end
        ptsc_pkg::PTSC_PLAY: begin
          if (play_idx == count && !play_wait && !rd_valid) begin
            state <= ptsc_pkg::PTSC_DONE;
          end
        end
        ptsc_pkg::PTSC_DONE, ptsc_pkg::PTSC_ABORTED: begin
          if (capture_clear_command) begin
            state <= ptsc_pkg::PTSC_IDLE;
          end
        end
        default: state <= ptsc_pkg::PTSC_IDLE;
      endcase
    end
  end

  // Abort timer from arm
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      timer <= 32'h0;
    end else if (state == ptsc_pkg::PTSC_IDLE && arm_cmd) begin
      timer <= abort_window;
    end else if (timer != 32'h0 && (state == ptsc_pkg::PTSC_WAIT_START
      || state == ptsc_pkg::PTSC_WAIT_STEP)) begin
      timer <= timer - 32'h1;
    end
  end

  // Sticky abort until clear
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      abort_flag <= 1'b0;
    end else if (state == ptsc_pkg::PTSC_ABORTED && !capture_clear_command) begin
      abort_flag <= 1'b1;
    end else if (capture_clear_command) begin
      abort_flag <= 1'b0;
    end
  end

  // Record count, emptied by clear in DONE or ABORTED
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      count <= '0;
    end else if (capture_clear_command && (state == ptsc_pkg::PTSC_DONE
      || state == ptsc_pkg::PTSC_ABORTED)) begin
      count <= '0;
    end else if (capture && timer != 32'h0) begin
      count <= count + 1'b1;
    end
  end

  assign buf_bus.wr_en = capture && timer != 32'h0;
  assign buf_bus.wr_addr = count[AW-1:0];
  assign buf_bus.wr_data = ref_axis_input;
  assign buf_bus.rd_addr = play_idx[AW-1:0];

  // ****************************************
  // Playback
  // ****************************************
  // Read in order, one event per record, wait for ack
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      play_idx <= '0;
      play_wait <= 1'b0;
      rd_valid <= 1'b0;
      playback_event <= 1'b0;
      playback_data <= '0;
    end else begin
      playback_event <= 1'b0;
      rd_valid <= 1'b0;
      if (state != ptsc_pkg::PTSC_PLAY) begin
        play_idx <= '0;
        play_wait <= 1'b0;
      end else if (!play_wait && !rd_valid && play_idx != count) begin
        rd_valid <= 1'b1;
      end else if (rd_valid) begin
        playback_event <= 1'b1;
        playback_data <= buf_bus.rd_data;
        play_wait <= 1'b1;
        play_idx <= play_idx + 1'b1;
      end else if (play_wait && playback_ack) begin
        play_wait <= 1'b0;
      end
    end
  end

  // Suppress display while scanning
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      display_suppress <= 1'b0;
    end else begin
      display_suppress <= state == ptsc_pkg::PTSC_WAIT_START
        || state == ptsc_pkg::PTSC_WAIT_STEP;
    end
  end

  // ****************************************
  // Interrupts
  // ****************************************
  assign irq_set = {rd_valid, (state == ptsc_pkg::PTSC_ABORTED) && !abort_flag,
    (state == ptsc_pkg::PTSC_PLAY) && (play_idx == count) && !play_wait && !rd_valid,
    buf_bus.wr_en};

  // Sticky status, set wins over clear
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_status <= '0;
      irq <= 1'b0;
    end else begin
      irq_status <= irq_set | (irq_status & ~((wr_strobe && ap_addr == ptsc_pkg::OFS_IRQ_CLEAR)
        ? hwdata[ptsc_pkg::IRQ_BITS-1:0] : '0));
      irq <= |(irq_status & irq_enable);
    end
  end

endmodule : ptsc_top

// *** inc/ptsc_pkg.sv ***
/*
 * Package for the position triggered scan capture block: register offsets,
 * field positions, reset values and states.
 * Assumes a single 100 MHz clock domain and an AHB-Lite register bus.
 */
package ptsc_pkg;

  // ****************************************
  // Register byte offsets
  // ****************************************
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_REF_SEL = 8'h04;
  localparam logic [7:0] OFS_TRIGGER_LEVEL = 8'h08;
  localparam logic [7:0] OFS_STEP = 8'h0C;
  localparam logic [7:0] OFS_SAMPLE_TARGET = 8'h10;
  localparam logic [7:0] OFS_ABORT_WINDOW = 8'h14;
  localparam logic [7:0] OFS_STATUS = 8'h18;
  localparam logic [7:0] OFS_IRQ_STATUS = 8'h1C;
  localparam logic [7:0] OFS_IRQ_ENABLE = 8'h20;
  localparam logic [7:0] OFS_IRQ_CLEAR = 8'h24;
  localparam logic [7:0] OFS_COUNT = 8'h28;
  localparam logic [7:0] OFS_PLAY_INDEX = 8'h2C;

  // ****************************************
  // Field positions
  // ****************************************
  localparam int CTRL_ARM = 0;
  localparam int CTRL_CLEAR = 1;
  localparam int CTRL_PLAY_ACK = 2;
  localparam int ST_BUSY = 0;
  localparam int ST_ABORT = 1;
  localparam int ST_DONE = 2;
  localparam int ST_PLAYING = 3;
  localparam int ST_SUPPRESS = 4;
  localparam int IRQ_CAPTURE = 0;
  localparam int IRQ_DONE = 1;
  localparam int IRQ_ABORT = 2;
  localparam int IRQ_PLAY = 3;
  localparam int IRQ_BITS = 4;

  // ****************************************
  // Reset values and timing
  // ****************************************
  localparam logic [31:0] RST_WORD = 32'h0000_0000;
  localparam logic [31:0] RST_ABORT_WINDOW = 32'h05F5_E100;
  localparam int CLK_MHZ = 100;
  localparam int PLAY_GAP_NS = 20;
  localparam int PLAY_GAP_CYC = (PLAY_GAP_NS * CLK_MHZ + 999) / 1000;

  // ****************************************
  // Sequencer states
  // ****************************************
  typedef enum logic [2:0] {
    PTSC_IDLE,
    PTSC_WAIT_START,
    PTSC_WAIT_STEP,
    PTSC_PLAY,
    PTSC_DONE,
    PTSC_ABORTED
  } ptsc_state_e;

endpackage : ptsc_pkg

// *** inc/ptsc_buf_if.sv ***
/*
 * Interface between sequencer and record buffer.
 * Assumes one clock; write and read ports are synchronous.
 */
`timescale 1ns/100ps
interface ptsc_buf_if #(
  parameter int CH = 4,
  parameter int W = 32,
  parameter int AW = 9
);
  logic wr_en;
  logic [AW-1:0] wr_addr;
  logic [CH*W-1:0] wr_data;
  logic [AW-1:0] rd_addr;
  logic [CH*W-1:0] rd_data;

  modport ctrl (output wr_en, output wr_addr, output wr_data, output rd_addr,
    input rd_data);
  modport mem (input wr_en, input wr_addr, input wr_data, input rd_addr,
    output rd_data);
endinterface : ptsc_buf_if

// *** verilog/ptsc_record_buf.sv ***
/*
 * Record buffer: one word holds all channels of one capture.
 * Assumes the sequencer writes addresses in order from zero.
 */
`timescale 1ns/100ps
module ptsc_record_buf #(
  parameter int CH = 4,
  parameter int W = 32,
  parameter int AW = 9
) (
  // Clock
  input wire logic hclk,
  // Buffer port
  ptsc_buf_if.mem bus
);

  logic [CH*W-1:0] mem [0:(1<<AW)-1];
  logic [CH*W-1:0] rd_q;

  // ****************************************
  // Storage
  // ****************************************
  // Sequential write, registered read
  always_ff @(posedge hclk) begin
    if (bus.wr_en) begin
      mem[bus.wr_addr] <= bus.wr_data;
    end
    rd_q <= mem[bus.rd_addr];
  end

  assign bus.rd_data = rd_q;

endmodule : ptsc_record_buf

// *** verilog/ptsc_step_cmp.sv ***
/*
 * Boundary comparator: tests whether a position has reached a boundary
 * in the chosen direction. Pure combinational.
 * Assumes signed two's complement positions.
 */
`timescale 1ns/100ps
module ptsc_step_cmp #(
  parameter int W = 32
) (
  // Operands
  input wire logic signed [W-1:0] pos,
  input wire logic signed [W-1:0] boundary,
  input wire logic signed [W-1:0] step,
  input wire logic rising,
  // Results
  output logic reached,
  output logic cross_up,
  output logic cross_dn
);

  // Reached in direction, and first boundaries either way
  always_comb begin
    reached = rising ? (pos >= boundary) : (pos <= boundary);
    cross_up = pos >= (boundary + step);
    cross_dn = pos <= (boundary - step);
  end

endmodule : ptsc_step_cmp

// *** verif/ptsc_top_assertions.sv ***
/* Checker on the ports of ptsc_top.
   Assumes one clock hclk and active-low reset hresetn. */
`timescale 1ns/100ps
module ptsc_chk #(
  parameter int CH = 4,
  parameter int W = 32
) (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Bus
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  input wire logic hreadyout,
  input wire logic hresp,
  // Playback and status
  input wire logic playback_event,
  input wire logic [CH*W-1:0] playback_data,
  input wire logic playback_ack,
  input wire logic display_suppress,
  input wire logic irq
);
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);

  // ****************************************
  // Properties
  // ****************************************
  property p_okay;
    hresp == 1'b0;
  endproperty
  a_okay: assert property (p_okay)
    else $error("hresp not OKAY");
  property p_ready;
    hreadyout == 1'b1;
  endproperty
  a_ready: assert property (p_ready)
    else $error("wait state inserted");
  property p_rdata;
    !$stable(hrdata) |-> $past(hsel && hready && htrans[1] && !hwrite);
  endproperty
  a_rdata: assert property (p_rdata)
    else $error("hrdata changed without read");
  property p_pulse;
    playback_event |=> !playback_event;
  endproperty
  a_pulse: assert property (p_pulse)
    else $error("playback event longer than a cycle");
  property p_hold;
    !$stable(playback_data) |-> playback_event;
  endproperty
  a_hold: assert property (p_hold)
    else $error("record changed without event");
  property p_quiet;
    display_suppress |-> !playback_event;
  endproperty
  a_quiet: assert property (p_quiet)
    else $error("playback while capturing");
  property p_ack;
    playback_event && !playback_ack ##1 !playback_ack [*3] |=> !playback_event;
  endproperty
  a_ack: assert property (p_ack)
    else $error("next record without ack");
  property p_mask;
    hsel && hready && htrans[1] && hwrite && haddr[7:0] == ptsc_pkg::OFS_IRQ_ENABLE
      ##1 hwdata == 32'h0000_0000 |=> ##[1:2] !irq;
  endproperty
  a_mask: assert property (p_mask)
    else $error("irq stays up when masked");
endmodule : ptsc_chk

bind ptsc_top ptsc_chk #(.CH(CH), .W(W)) u_chk (.hclk(hclk), .hresetn(hresetn),
  .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata),
  .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
  .playback_event(playback_event), .playback_data(playback_data),
  .playback_ack(playback_ack), .display_suppress(display_suppress), .irq(irq));

// *** verif/ptsc_probe_model.sv ***
/* Encoder and probe model on the channel inputs.
   Assumes the bench sets the encoder position; probes sit at fixed offsets. */
`timescale 1ns/100ps
module ptsc_probe_model #(
  parameter int CH = 4,
  parameter int W = 32
) (
  // Clock
  input wire logic hclk,
  // Encoder position
  input wire logic signed [W-1:0] pos,
  // Channels
  output logic [CH*W-1:0] ref_axis_input
);
  // Sample all channels together; top channel is the encoder itself
  always_ff @(posedge hclk) begin
    for (int k = 0; k < CH; k++) begin
      ref_axis_input[k*W+:W] <= W'(pos - (CH - 1 - k) * 4096);
    end
  end
endmodule : ptsc_probe_model

// *** verif/ptsc_top_test.sv ***
/* Self-checking bench for ptsc_top.
   Assumes the probe model on the channels and the bench as consumer. */
`timescale 1ns/100ps
module ptsc_top_test;
  logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, playback_ack = 0;
  logic [31:0] haddr = 0, hwdata = 0, rd, hrdata;
  logic [1:0] htrans = 0;
  logic signed [31:0] pos = 0;
  logic hready, hreadyout, hresp, playback_event, display_suppress, irq;
  logic [127:0] playback_data, ref_axis_input;
  int errors = 0, check_count = 0;

  // Single slave: its ready is the bus ready
  assign hready = hreadyout;

  ptsc_probe_model u_probe (.hclk(hclk), .pos(pos), .ref_axis_input(ref_axis_input));
  ptsc_top dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata), .hready(hready),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .ref_axis_input(ref_axis_input), .playback_event(playback_event),
    .playback_data(playback_data), .playback_ack(playback_ack),
    .display_suppress(display_suppress), .irq(irq));

  // Clock
  initial begin
    forever #5 hclk = ~hclk;
  end

  // ****************************************
  // Helpers
  // ****************************************
  task automatic chk(input string n, input logic [127:0] g, input logic [127:0] e);
    check_count++;
    if (g !== e) begin
      errors++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask : chk

  // One single AHB transfer, read data into rd
  task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= {24'h000000, a};
    htrans <= 2'b10;
    hwrite <= w;
    do @(posedge hclk); while (hready !== 1'b1);
    htrans <= 2'b00;
    hsel <= 1'b0;
    hwdata <= d;
    do @(posedge hclk); while (hready !== 1'b1);
    rd = hrdata;
  endtask : bus

  task automatic rchk(input logic [7:0] a, input logic [31:0] e);
    bus(a, 1'b0, 32'h0);
    chk($sformatf("reg_%h", a), rd, e);
  endtask : rchk

  task automatic step(input int p);
    pos <= p;
    repeat (3) @(posedge hclk);
  endtask : step

  function automatic logic [127:0] rec(input int p);
    for (int k = 0; k < 4; k++) begin
      rec[k*32+:32] = p - (3 - k) * 4096;
    end
  endfunction : rec

  // Wait for one record, check it, then acknowledge late
  task automatic get_rec(input int p);
    int i;
    i = 0;
    do begin
      @(posedge hclk);
      i++;
    end while (playback_event !== 1'b1 && i < 60);
    chk("playback_event", playback_event, 1'b1);
    chk("playback_data", playback_data, rec(p));
    repeat (4) @(posedge hclk);
    playback_ack <= 1'b1;
    @(posedge hclk);
    playback_ack <= 1'b0;
  endtask : get_rec

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_regs;
    rchk(ptsc_pkg::OFS_ABORT_WINDOW, ptsc_pkg::RST_ABORT_WINDOW);
    rchk(ptsc_pkg::OFS_STATUS, ptsc_pkg::RST_WORD);
    bus(8'h40, 1'b1, 32'hFFFF_FFFF);
    rchk(8'h40, 32'h0000_0000);
    bus(ptsc_pkg::OFS_REF_SEL, 1'b1, 32'h0000_0003);
    bus(ptsc_pkg::OFS_TRIGGER_LEVEL, 1'b1, 32'h0000_0064);
    bus(ptsc_pkg::OFS_STEP, 1'b1, 32'h0000_000A);
    bus(ptsc_pkg::OFS_SAMPLE_TARGET, 1'b1, 32'h0000_0004);
    bus(ptsc_pkg::OFS_ABORT_WINDOW, 1'b1, 32'h0000_0BB8);
    bus(ptsc_pkg::OFS_IRQ_ENABLE, 1'b1, 32'h0000_000F);
    rchk(ptsc_pkg::OFS_STEP, 32'h0000_000A);
  endtask : t_regs

  task automatic t_scan;
    step(50);
    bus(ptsc_pkg::OFS_CTRL, 1'b1, 32'h0000_0001);
    rchk(ptsc_pkg::OFS_STATUS, 32'h0000_0011);
    chk("display_suppress", display_suppress, 1'b1);
    step(99);
    rchk(ptsc_pkg::OFS_COUNT, 32'h0000_0000);
    step(100);
    rchk(ptsc_pkg::OFS_COUNT, 32'h0000_0001);
    step(108);
    step(92);
    rchk(ptsc_pkg::OFS_COUNT, 32'h0000_0001);
    step(115);
    rchk(ptsc_pkg::OFS_COUNT, 32'h0000_0002);
    step(89);
    rchk(ptsc_pkg::OFS_COUNT, 32'h0000_0002);
    step(125);
    rchk(ptsc_pkg::OFS_COUNT, 32'h0000_0003);
    pos <= 131;
    get_rec(100);
    get_rec(115);
    get_rec(125);
    get_rec(131);
    rchk(ptsc_pkg::OFS_STATUS, 32'h0000_0005);
    rchk(ptsc_pkg::OFS_COUNT, 32'h0000_0004);
    rchk(ptsc_pkg::OFS_IRQ_STATUS, 32'h0000_000B);
    chk("irq", irq, 1'b1);
    bus(ptsc_pkg::OFS_IRQ_ENABLE, 1'b1, 32'h0000_0000);
    step(131);
    chk("irq", irq, 1'b0);
    bus(ptsc_pkg::OFS_IRQ_ENABLE, 1'b1, 32'h0000_000F);
    bus(ptsc_pkg::OFS_IRQ_CLEAR, 1'b1, 32'h0000_000F);
    rchk(ptsc_pkg::OFS_IRQ_STATUS, 32'h0000_0000);
    bus(ptsc_pkg::OFS_CTRL, 1'b1, 32'h0000_0001);
    rchk(ptsc_pkg::OFS_COUNT, 32'h0000_0004);
    bus(ptsc_pkg::OFS_CTRL, 1'b1, 32'h0000_0002);
    rchk(ptsc_pkg::OFS_COUNT, 32'h0000_0000);
  endtask : t_scan

  task automatic t_abort;
    bus(ptsc_pkg::OFS_ABORT_WINDOW, 1'b1, 32'h0000_0032);
    step(0);
    bus(ptsc_pkg::OFS_CTRL, 1'b1, 32'h0000_0001);
    repeat (30) @(posedge hclk);
    rchk(ptsc_pkg::OFS_STATUS, 32'h0000_0011);
    repeat (40) @(posedge hclk);
    rchk(ptsc_pkg::OFS_STATUS, 32'h0000_0003);
    rchk(ptsc_pkg::OFS_IRQ_STATUS, 32'h0000_0004);
    chk("irq", irq, 1'b1);
    repeat (20) @(posedge hclk);
    rchk(ptsc_pkg::OFS_STATUS, 32'h0000_0003);
    bus(ptsc_pkg::OFS_CTRL, 1'b1, 32'h0000_0002);
    rchk(ptsc_pkg::OFS_STATUS, 32'h0000_0000);
  endtask : t_abort

  // Falling scan: start above trigger, lock the downward direction
  task automatic t_fall;
    bus(ptsc_pkg::OFS_ABORT_WINDOW, 1'b1, 32'h0000_0BB8);
    bus(ptsc_pkg::OFS_SAMPLE_TARGET, 1'b1, 32'h0000_0003);
    step(150);
    bus(ptsc_pkg::OFS_CTRL, 1'b1, 32'h0000_0001);
    step(100);
    rchk(ptsc_pkg::OFS_COUNT, 32'h0000_0001);
    step(88);
    rchk(ptsc_pkg::OFS_COUNT, 32'h0000_0002);
    step(85);
    rchk(ptsc_pkg::OFS_COUNT, 32'h0000_0002);
    pos <= 79;
    get_rec(100);
    get_rec(88);
    get_rec(79);
    rchk(ptsc_pkg::OFS_STATUS, 32'h0000_0005);
    bus(ptsc_pkg::OFS_CTRL, 1'b1, 32'h0000_0002);
    rchk(ptsc_pkg::OFS_COUNT, 32'h0000_0000);
  endtask : t_fall

  task automatic end_sim;
    if (errors == 0 && check_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : end_sim

  // Main sequence
  initial begin
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    t_regs();
    t_scan();
    t_abort();
    t_fall();
    end_sim();
  end

  // Watchdog
  initial begin
    repeat (20000) @(posedge hclk);
    errors++;
    end_sim();
  end
endmodule : ptsc_top_test
